//--- verilog/mie_core.sv
// execute core: accumulator, data memory, status flags, pc, stack, watchdog
// assumes an issuer that waits for ready_out and a register master on clk_sys_in
//
// Contract
// - adc to acc: acc plus byte plus carry
// - adc to memory: same sum into byte
// - add memory or immediate into accumulator
// - add to memory writes sum to byte
// - and into accumulator, only zero flag
// - and to memory, only zero flag
// - call pushes next pc, loads target
// - clear byte writes zero, flags kept
// - clear bit touches selected bit only
// - watchdog clear zeroes counter, pdf, timeout
// - preclear pair clears only when both ran
// - invert byte in place, zero flag
// - invert into accumulator, memory kept
// - decimal adjust low nibble rule
// - decimal adjust high nibble, result to memory
// - decrement to memory or accumulator, zero flag
// - increment to memory or accumulator, zero flag
// - halt stops execution, pc plus one
// - halt clears watchdog, sets pdf, clears timeout
// - jump loads target, stack untouched
// - pc low destination adds one cycle
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "mie_cfg.svh"

module mie_core import mie_pkg::*; (
  input  wire logic              clk_sys_in,   // system clock
  input  wire logic              rstn_in,      // async reset, low
  input  wire logic              instr_valid_in, // instruction offered
  input  wire mie_op_type        instr_op_in,  // operation
  input  wire logic [`MEM_AW-1:0] instr_addr_in, // data memory index
  input  wire logic [7:0]        instr_imm_in, // immediate byte
  input  wire logic [2:0]        instr_bit_in, // bit select
  input  wire logic [`PC_W-1:0]  instr_target_in, // branch target
  output logic                   ready_out,    // instruction may issue
  output logic [7:0]             acc_out,      // accumulator
  output logic [7:0]             status_out,   // flag byte
  output logic [`PC_W-1:0]       pc_out,       // program counter
  output logic                   halted_out,   // power-down state
  input  wire logic [7:0]        addr_in,      // register address
  input  wire logic [7:0]        wr_data_in,   // write data
  input  wire logic              wr_in,        // write strobe
  input  wire logic              rd_in,        // read strobe
  output logic [7:0]             rd_data_out   // read data, next cycle
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]          accumulator_reg;       // accumulator
  logic [7:0]          mem_ff [`MEM_DEP];     // data memory
  logic [`PC_W-1:0]    pc_ff;                 // program counter
  logic [`PC_W-1:0]    stk_ff [`STK_DEP];     // return stack
  logic [`STK_AW-1:0]  sp_ff;                 // stack pointer
  logic                c_ff;                  // carry
  logic                aux_carry_flag;        // carry out of bit 3
  logic                z_ff;                  // zero
  logic                overflow_flag;         // signed overflow
  logic                powerdown_flag;        // set by halt
  logic                watchdog_timeout_flag; // watchdog expired
  logic                pa_ff;                 // preclear a has run
  logic                pb_ff;                 // preclear b has run
  logic [7:0]          watchdog_counter;      // watchdog count
  logic [`WDT_PS_W-1:0] ps_ff;                // watchdog prescaler
  logic [`CNT_W-1:0]   cnt_ff;                // clocks left in instruction
  logic                halted_ff;             // execution stopped

  // ----------------------------------------------------------------
  // operand fetch and alu
  // ----------------------------------------------------------------
  logic                issue;      // instruction taken this edge
  logic                pcl_hit;    // operand index aliases pc low byte
  logic [7:0]          mem_rd;     // addressed byte
  logic [7:0]          opnd;       // second operand
  logic                cin;        // carry into adder
  logic [8:0]          sum9;       // adder result with carry out
  logic [4:0]          lo5;        // low nibble sum, bit 4 is aux carry
  logic [7:0]          res;        // result byte
  logic                wr_acc;     // result goes to accumulator
  logic                wr_dst;     // result goes to memory byte
  logic                upd_add;    // update ov, ac, c
  logic                upd_z;      // update zero
  logic                upd_cd;     // decimal adjust may set carry
  logic [`CNT_W-1:0]   icyc;       // instruction cycles
  logic                dlo_adj;    // low nibble needs adjust
  logic                nibble_adjust_carry; // carry into high nibble
  logic [4:0]          hi5;        // high nibble plus nibble carry
  logic                dhi_adj;    // high nibble needs adjust
  logic                wd_clear;   // watchdog clear this edge
  logic                bus_mem;    // bus address in memory window

  assign issue   = instr_valid_in && ready_out;
  assign pcl_hit = (instr_addr_in == `PCL_IDX);
  assign mem_rd  = pcl_hit ? pc_ff[7:0] : mem_ff[instr_addr_in];
  assign bus_mem = (addr_in[7:`MEM_AW] == `MEM_WIN);

  // one combinational decode; every path assigns every output
  always_comb begin
    opnd = (instr_op_in == OP_ADD_AI || instr_op_in == OP_AND_AI) ? instr_imm_in : mem_rd;
    cin  = (instr_op_in == OP_ADC_A || instr_op_in == OP_ADC_M) && c_ff;
    sum9 = {1'b0, accumulator_reg} + {1'b0, opnd} + {8'h00, cin};
    lo5  = {1'b0, accumulator_reg[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    // decimal adjust works on the accumulator, result lands in memory
    dlo_adj = (accumulator_reg[3:0] > 4'h9) || aux_carry_flag;
    nibble_adjust_carry = dlo_adj && !aux_carry_flag;
    hi5     = {1'b0, accumulator_reg[7:4]} + {4'h0, nibble_adjust_carry};
    dhi_adj = (hi5 > 5'h09) || c_ff;
    res     = 8'h00;
    wr_acc  = 1'b0;
    wr_dst  = 1'b0;
    upd_add = 1'b0;
    upd_z   = 1'b0;
    upd_cd  = 1'b0;
    icyc    = 4'h1;
    case (instr_op_in)
      OP_ADC_A, OP_ADD_A, OP_ADD_AI: begin
        res = sum9[7:0]; wr_acc = 1'b1; upd_add = 1'b1; upd_z = 1'b1;
      end
      OP_ADC_M, OP_ADD_M: begin
        res = sum9[7:0]; wr_dst = 1'b1; upd_add = 1'b1; upd_z = 1'b1;
      end
      OP_AND_A, OP_AND_AI: begin
        res = accumulator_reg & opnd; wr_acc = 1'b1; upd_z = 1'b1;
      end
      OP_AND_M: begin
        res = accumulator_reg & opnd; wr_dst = 1'b1; upd_z = 1'b1;
      end
      OP_CLR_M:   begin res = 8'h00; wr_dst = 1'b1; end
      OP_CLR_BIT: begin
        res = mem_rd & ~(8'h01 << instr_bit_in); wr_dst = 1'b1;
      end
      OP_INV_M:   begin res = ~mem_rd; wr_dst = 1'b1; upd_z = 1'b1; end
      OP_INV_A:   begin res = ~mem_rd; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_DAA: begin
        res[3:0] = dlo_adj ? accumulator_reg[3:0] + 4'h6 : accumulator_reg[3:0];
        res[7:4] = dhi_adj ? hi5[3:0] + 4'h6 : hi5[3:0];
        wr_dst = 1'b1; upd_cd = dhi_adj;
      end
      OP_DEC_M: begin res = mem_rd - 8'h01; wr_dst = 1'b1; upd_z = 1'b1; end
      OP_DEC_A: begin res = mem_rd - 8'h01; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_INC_M: begin res = mem_rd + 8'h01; wr_dst = 1'b1; upd_z = 1'b1; end
      OP_INC_A: begin res = mem_rd + 8'h01; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_CALL, OP_JMP: icyc = 4'h2;
      default: icyc = 4'h1;  // watchdog, halt and nop touch no data path
    endcase
    if (wr_dst && pcl_hit) begin
      icyc = icyc + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // instruction timing and power-down
  // ----------------------------------------------------------------
  // results commit on the issue edge; the counter only paces the issuer
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_ff <= 4'h0;
    end else if (issue) begin
      cnt_ff <= icyc * `ICYC_CLKS - 4'h1;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  // halt holds until reset: the clock it would stop belongs to the chip
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      halted_ff <= 1'b0;
    end else if (issue && instr_op_in == OP_HALT) begin
      halted_ff <= 1'b1;
    end
  end

  assign ready_out = (cnt_ff == 4'h0) && !halted_ff;

  // ----------------------------------------------------------------
  // program counter and stack
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_ff <= `PC_RST;
    end else if (issue) begin
      if (instr_op_in == OP_CALL || instr_op_in == OP_JMP) begin
        pc_ff <= instr_target_in;
      end else if (wr_dst && pcl_hit) begin
        pc_ff <= {pc_ff[`PC_W-1:8], res};
      end else begin
        pc_ff <= pc_ff + 12'h001;
      end
    end
  end

  // the stack wraps when overfilled, like a small hardware stack would
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sp_ff <= 3'h0;
      for (int i = 0; i < `STK_DEP; i++) begin
        stk_ff[i] <= `PC_RST;
      end
    end else if (issue && instr_op_in == OP_CALL) begin
      stk_ff[sp_ff] <= pc_ff + 12'h001;
      sp_ff         <= sp_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // accumulator and data memory
  // ----------------------------------------------------------------
  // an instruction write beats a bus write in the same cycle
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      accumulator_reg <= 8'h00;
    end else if (issue && wr_acc) begin
      accumulator_reg <= res;
    end else if (wr_in && addr_in == `REG_ACC) begin
      accumulator_reg <= wr_data_in;
    end
  end

  for (genvar i = 0; i < `MEM_DEP; i++) begin : g_mem
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        mem_ff[i] <= 8'h00;
      end else if (issue && wr_dst && !pcl_hit && instr_addr_in == `MEM_AW'(i)) begin
        mem_ff[i] <= res;
      end else if (wr_in && bus_mem && addr_in[`MEM_AW-1:0] == `MEM_AW'(i)) begin
        mem_ff[i] <= wr_data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // arithmetic flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      c_ff           <= 1'b0;
      aux_carry_flag <= 1'b0;
      z_ff           <= 1'b0;
      overflow_flag  <= 1'b0;
    end else if (issue) begin
      if (upd_add) begin
        c_ff           <= sum9[8];
        aux_carry_flag <= lo5[4];
        overflow_flag  <= (accumulator_reg[7] == opnd[7]) && (sum9[7] != opnd[7]);
      end
      if (upd_cd) begin
        c_ff <= 1'b1;
      end
      if (upd_z) begin
        z_ff <= (res == 8'h00);
      end
    end else if (wr_in && addr_in == `REG_STATUS) begin
      c_ff           <= wr_data_in[`FLG_C];
      aux_carry_flag <= wr_data_in[`FLG_AC];
      z_ff           <= wr_data_in[`FLG_Z];
      overflow_flag  <= wr_data_in[`FLG_OV];
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  // a preclear completes when the other half has already been recorded
  assign wd_clear = issue && (instr_op_in == OP_CLR_WDT
                  || (instr_op_in == OP_PRECLR_A && pb_ff)
                  || (instr_op_in == OP_PRECLR_B && pa_ff));

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
    end else if (wd_clear) begin
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
    end else if (issue && instr_op_in == OP_PRECLR_A) begin
      pa_ff <= 1'b1;
    end else if (issue && instr_op_in == OP_PRECLR_B) begin
      pb_ff <= 1'b1;
    end
  end

  // counting stops while halted since the system clock would be off
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ps_ff            <= 4'h0;
      watchdog_counter <= 8'h00;
    end else if (wd_clear || (issue && instr_op_in == OP_HALT)) begin
      ps_ff            <= 4'h0;
      watchdog_counter <= 8'h00;
    end else if (!halted_ff) begin
      ps_ff <= ps_ff + 4'h1;
      if (ps_ff == `WDT_PS_MAX) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // expiry wins over a clear landing in the same cycle
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag        <= 1'b0;
    end else begin
      if (!halted_ff && ps_ff == `WDT_PS_MAX && watchdog_counter == `WDT_MAX) begin
        watchdog_timeout_flag <= 1'b1;
      end else if (wd_clear || (issue && instr_op_in == OP_HALT)) begin
        watchdog_timeout_flag <= 1'b0;
      end
      if (issue && instr_op_in == OP_HALT) begin
        powerdown_flag <= 1'b1;
      end else if (wd_clear) begin
        powerdown_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port and outputs
  // ----------------------------------------------------------------
  always_comb begin
    status_out = 8'h00;
    status_out[`FLG_C]   = c_ff;
    status_out[`FLG_AC]  = aux_carry_flag;
    status_out[`FLG_Z]   = z_ff;
    status_out[`FLG_OV]  = overflow_flag;
    status_out[`FLG_PDF] = powerdown_flag;
    status_out[`FLG_TO]  = watchdog_timeout_flag;
    status_out[`FLG_PA]  = pa_ff;
    status_out[`FLG_PB]  = pb_ff;
  end

  // unmapped addresses read as zero; data stands one cycle only
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 8'h00;
    end else if (!rd_in) begin
      rd_data_out <= 8'h00;
    end else if (bus_mem) begin
      rd_data_out <= mem_ff[addr_in[`MEM_AW-1:0]];
    end else begin
      case (addr_in)
        `REG_ACC:    rd_data_out <= accumulator_reg;
        `REG_STATUS: rd_data_out <= status_out;
        `REG_PCL:    rd_data_out <= pc_ff[7:0];
        `REG_PCH:    rd_data_out <= {4'h0, pc_ff[`PC_W-1:8]};
        `REG_WDT:    rd_data_out <= watchdog_counter;
        default:     rd_data_out <= 8'h00;
      endcase
    end
  end

  assign acc_out    = accumulator_reg;
  assign pc_out     = pc_ff;
  assign halted_out = halted_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence busy_one_s;  !ready_out [*3] ##1 ready_out; endsequence
  sequence busy_two_s;  !ready_out [*7] ##1 ready_out; endsequence

  adc_acc_sum_a: assert property (issue && instr_op_in == OP_ADC_A |=>
    accumulator_reg == 8'($past(accumulator_reg) + $past(mem_rd) + {7'h00, $past(c_ff)}))
    else $error("adc result wrong");
  add_carry_out_a: assert property (issue && instr_op_in == OP_ADD_AI |=>
    c_ff == $past(sum9[8]) && z_ff == (accumulator_reg == 8'h00))
    else $error("add flags wrong");
  and_flags_kept_a: assert property (issue && instr_op_in == OP_AND_A |=>
    $stable(c_ff) && $stable(overflow_flag) && z_ff == (accumulator_reg == 8'h00))
    else $error("and changed flags");
  call_push_a: assert property (issue && instr_op_in == OP_CALL |=>
    pc_ff == $past(instr_target_in) && stk_ff[$past(sp_ff)] == $past(pc_ff) + 12'h001)
    else $error("call wrong");
  jump_stack_kept_a: assert property (issue && instr_op_in == OP_JMP |=>
    pc_ff == $past(instr_target_in) && $stable(sp_ff) && $stable(stk_ff[0]))
    else $error("jump wrong");
  preclear_single_a: assert property (issue && instr_op_in == OP_PRECLR_A && !pb_ff |=>
    pa_ff && $stable(powerdown_flag)) else $error("lone preclear acted");
  halt_entry_a: assert property (issue && instr_op_in == OP_HALT |=>
    powerdown_flag && !watchdog_timeout_flag && watchdog_counter == 8'h00 && !ready_out)
    else $error("halt entry wrong");
  icyc_one_a: assert property (issue && icyc == 4'h1 && instr_op_in != OP_HALT
    |=> busy_one_s) else $error("one cycle length wrong");
  icyc_pcl_a: assert property (issue && wr_dst && pcl_hit && icyc == 4'h2 |=> busy_two_s)
    else $error("pc low extra cycle missing");
  inc_acc_a: assert property (issue && instr_op_in == OP_INC_A |=>
    accumulator_reg == 8'($past(mem_rd) + 8'h01) && z_ff == (accumulator_reg == 8'h00))
    else $error("increment wrong");

endmodule // mie_core

//--- verilog/mie_cfg.svh
// offsets, field positions, reset values and timing counts of the execute core
// assumed to be included by the core module only
`ifndef MIE_CFG_SVH
`define MIE_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define ICYC_CLKS     4'h4
`define CNT_W         4

// ----------------------------------------------------------------
// storage sizes
// ----------------------------------------------------------------
`define PC_W    12
`define MEM_AW  5
`define MEM_DEP 32
`define STK_AW  3
`define STK_DEP 8
`define PCL_IDX 5'h02
`define PC_RST  12'h000

// ----------------------------------------------------------------
// watchdog
// ----------------------------------------------------------------
`define WDT_PS_W 4
`define WDT_PS_MAX 4'hF
`define WDT_MAX  8'hFF

// ----------------------------------------------------------------
// register map and status field positions
// ----------------------------------------------------------------
`define REG_ACC    8'h00
`define REG_STATUS 8'h01
`define REG_PCL    8'h02
`define REG_PCH    8'h03
`define REG_WDT    8'h04
`define MEM_WIN    3'h4
`define FLG_C   0
`define FLG_AC  1
`define FLG_Z   2
`define FLG_OV  3
`define FLG_PDF 4
`define FLG_TO  5
`define FLG_PA  6
`define FLG_PB  7

`endif

//--- verilog/mie_pkg.sv
// types shared by the execute core and its bench
// assumes nothing of its surroundings
package mie_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_ADC_A, OP_ADC_M, OP_ADD_A, OP_ADD_AI, OP_ADD_M,
    OP_AND_A, OP_AND_AI, OP_AND_M, OP_CALL, OP_CLR_M, OP_CLR_BIT,
    OP_CLR_WDT, OP_PRECLR_A, OP_PRECLR_B, OP_INV_M, OP_INV_A, OP_DAA,
    OP_DEC_M, OP_DEC_A, OP_INC_M, OP_INC_A, OP_HALT, OP_JMP
  } mie_op_type;
endpackage

//--- dv/mie_issuer.sv
// instruction issuer model that stands in front of the execute core
// assumes it shares clk_sys_in with the core and that the bench calls issue()
`timescale 1ns/10ps

module mie_issuer import mie_pkg::*; (
  input  wire logic        clk_sys_in,       // system clock
  input  wire logic        ready_out,        // core may take an instruction
  output mie_op_type       instr_op_out,     // operation
  output logic [4:0]       instr_addr_out,   // data memory index
  output logic [7:0]       instr_imm_out,    // immediate byte
  output logic [2:0]       instr_bit_out,    // bit select
  output logic [11:0]      instr_target_out, // branch target
  output logic             instr_valid_out   // offer strobe
);
  // ----------------------------------------------------------------
  // idle state at time zero
  // ----------------------------------------------------------------
  initial begin
    instr_valid_out  = 1'b0;
    instr_op_out     = OP_NOP;
    instr_addr_out   = 5'h00;
    instr_imm_out    = 8'h00;
    instr_bit_out    = 3'h0;
    instr_target_out = 12'h000;
  end

  // offer one instruction once the core is idle, then count busy cycles
  task automatic issue(input mie_op_type op, input logic [4:0] a, input logic [7:0] arg,
                       input logic [11:0] tgt, output int n);
    int k;
    k = 0;
    n = 0;
    @(negedge clk_sys_in);
    while (ready_out !== 1'b1 && k < 100) begin
      @(negedge clk_sys_in);
      k++;
    end
    @(posedge clk_sys_in);
    instr_valid_out  <= 1'b1;
    instr_op_out     <= op;
    instr_addr_out   <= a;
    instr_imm_out    <= arg;
    instr_bit_out    <= arg[2:0];
    instr_target_out <= tgt;
    @(posedge clk_sys_in);
    instr_valid_out <= 1'b0;
    // stale index and immediate are inverted so nothing leans on a held value
    {instr_addr_out, instr_imm_out} <= ~{a, arg};
    @(negedge clk_sys_in);
    // capped at 20 so a core that never comes back cannot hang the bench
    while (ready_out !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys_in);
    end
  endtask
endmodule // mie_issuer

//--- dv/tb_mcu_instruction_execute_subset.sv
// self-checking bench for the execute core, fed by the issuer model
// assumes the core package and header are compiled before this file
`timescale 1ns/10ps

module tb_mcu_instruction_execute_subset;
  import mie_pkg::*;
  logic        clk_sys_in, rstn_in, wr_in, rd_in, ready_out, halted_out; // control
  logic [7:0]  addr_in, wr_data_in, rd_data_out, acc_out, status_out;   // bus and state
  logic [11:0] pc_out, i_tgt;                // pc and issuer target
  logic [4:0]  i_addr;                       // issuer index
  logic [7:0]  i_imm;                        // issuer immediate
  logic [2:0]  i_bit;                        // issuer bit
  logic        i_valid;                      // issuer strobe
  mie_op_type  i_op;                         // issuer op
  int          bad_count, samples_checked, n; // tallies, busy count
  logic [63:0] r;                            // current row
  // row: op, acc, mem, status, arg, then expected acc, mem, status
  logic [63:0] rows [19] = '{
    64'h01_7F_00_01_00_80_00_0A, 64'h02_FF_00_01_00_FF_00_07, 64'h03_80_80_01_00_00_80_0D,
    64'h04_08_00_00_08_10_00_02, 64'h05_01_FF_00_00_01_00_07, 64'h06_F0_0F_0B_00_00_0F_0F,
    64'h07_3C_00_04_0F_0C_00_00, 64'h08_AA_55_00_00_AA_00_04, 64'h0A_11_A5_0F_00_11_00_0F,
    64'h0B_00_FF_00_07_00_7F_00, 64'h0F_00_FF_00_00_00_00_04, 64'h10_00_5A_04_00_A5_5A_00,
    64'h11_9A_00_00_00_9A_00_01, 64'h11_15_00_02_00_15_1B_02, 64'h12_00_01_00_00_00_00_04,
    64'h13_33_00_04_00_FF_00_00, 64'h14_00_FF_00_00_00_00_04, 64'h15_00_7F_04_00_80_7F_00,
    64'h00_5A_A5_0B_00_5A_A5_0B  // no operation leaves everything as it was
  };

  mie_core u_dut (.clk_sys_in, .rstn_in, .instr_valid_in(i_valid), .instr_op_in(i_op),
    .instr_addr_in(i_addr), .instr_imm_in(i_imm), .instr_bit_in(i_bit),
    .instr_target_in(i_tgt), .ready_out, .acc_out, .status_out, .pc_out, .halted_out,
    .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out);

  mie_issuer u_iss (.clk_sys_in, .ready_out, .instr_op_out(i_op), .instr_addr_out(i_addr),
    .instr_imm_out(i_imm), .instr_bit_out(i_bit), .instr_target_out(i_tgt),
    .instr_valid_out(i_valid));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // masked compare; table checks mask the watchdog bits that run on their own, watchdog checks mask the arithmetic flags
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    samples_checked++;
    if ((got & m) !== (exp & m)) begin
      bad_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(rd_data_out, e, m);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // free-running 25 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // run needs about 13k cycles; over twice that means a hang
  initial begin
    #(40 * 30000);
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn_in, wr_in, rd_in} = 3'b000;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    // unmapped and read-only writes must leave no trace
    bus_wr(8'h40, 8'hFF);
    bus_wr(8'h02, 8'h55);
    bus_rd(8'h00, 8'h00, 8'hFF);
    bus_rd(8'h01, 8'h00, 8'hFF);
    bus_rd(8'h02, 8'h00, 8'hFF);
    bus_rd(8'h40, 8'h00, 8'hFF);
    $display("test reset done");
    for (int i = 0; i < 19; i++) begin
      r = rows[i];
      bus_wr(8'h00, r[55:48]);
      bus_wr(8'h01, r[39:32]);
      bus_wr(8'h85, r[47:40]);
      u_iss.issue(mie_op_type'(r[60:56]), 5'h05, r[31:24], 12'h000, n);
      chk(8'(n), 8'h03, 8'hFF);
      chk(acc_out, r[23:16], 8'hFF);
      chk(status_out, r[7:0], 8'h0F);
      bus_rd(8'h00, r[23:16], 8'hFF);
      bus_rd(8'h85, r[15:8], 8'hFF);
      bus_rd(8'h01, r[7:0], 8'h0F);
    end
    $display("test table done");
    u_iss.issue(OP_CALL, 5'h00, 8'h00, 12'h345, n);
    chk(8'(n), 8'h07, 8'hFF);
    chk(pc_out[7:0], 8'h45, 8'hFF);
    u_iss.issue(OP_JMP, 5'h00, 8'h00, 12'h1FE, n);
    chk(8'(n), 8'h07, 8'hFF);
    bus_rd(8'h03, 8'h01, 8'hFF);
    u_iss.issue(OP_INC_M, 5'h02, 8'h00, 12'h000, n);
    chk(8'(n), 8'h07, 8'hFF);
    chk(pc_out[7:0], 8'hFF, 8'hFF);
    $display("test branch done");
    // let the watchdog expire so the clears have something to clear
    repeat (4200) @(posedge clk_sys_in);
    bus_rd(8'h01, 8'h20, 8'hF0);
    u_iss.issue(OP_PRECLR_A, 5'h00, 8'h00, 12'h000, n);
    bus_rd(8'h01, 8'h60, 8'hF0);
    u_iss.issue(OP_PRECLR_B, 5'h00, 8'h00, 12'h000, n);
    bus_rd(8'h01, 8'h00, 8'hF0);
    repeat (4200) @(posedge clk_sys_in);
    u_iss.issue(OP_PRECLR_B, 5'h00, 8'h00, 12'h000, n);
    bus_rd(8'h01, 8'hA0, 8'hF0);
    u_iss.issue(OP_CLR_WDT, 5'h00, 8'h00, 12'h000, n);
    bus_rd(8'h01, 8'h00, 8'hF0);
    bus_rd(8'h04, 8'h00, 8'hFF);
    $display("test watchdog done");
    repeat (4200) @(posedge clk_sys_in);
    u_iss.issue(OP_JMP, 5'h00, 8'h00, 12'h0A0, n);
    u_iss.issue(OP_HALT, 5'h00, 8'h00, 12'h000, n);
    chk(8'(n), 8'h14, 8'hFF);
    chk({7'h00, halted_out}, 8'h01, 8'hFF);
    chk(pc_out[7:0], 8'hA1, 8'hFF);
    bus_rd(8'h01, 8'h10, 8'hF0);
    bus_rd(8'h04, 8'h00, 8'hFF);
    $display("test halt done");
    // second reset in mid-run must bring the core back up
    @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(negedge clk_sys_in);
    chk({7'h00, halted_out}, 8'h00, 8'hFF);
    bus_rd(8'h00, 8'h00, 8'hFF);
    $display("test rereset done");
    tally_and_finish();
  end
endmodule // tb_mcu_instruction_execute_subset
